// ---- core/isc_pkg.sv ----
// Shared constants and types for the instruction state counter.
package isc_pkg;

  // Operation code fields of the first instruction word.
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int VARIANT_BIT = 7;

  // Widths.
  localparam int CNT_W = 4;
  localparam int STATES_W = 16;
  localparam int BLK_CNT_W = 8;

  // State cost per cycle, by cycle type and location.
  localparam logic [CNT_W-1:0] COST_FETCH_MEM = 4'h2;
  localparam logic [CNT_W-1:0] COST_BRANCH_MEM = 4'h2;
  localparam logic [CNT_W-1:0] COST_STACK_MEM = 4'h2;
  localparam logic [CNT_W-1:0] COST_BYTE_MEM = 4'h2;
  localparam logic [CNT_W-1:0] COST_BYTE_PERI_FAST = 4'h2;
  localparam logic [CNT_W-1:0] COST_BYTE_PERI_SLOW = 4'h3;
  localparam logic [CNT_W-1:0] COST_WORD_MEM = 4'h2;
  localparam logic [CNT_W-1:0] internal_state_cost = 4'h1;

  // Block move timing: states per byte and fixed overhead.
  localparam logic [STATES_W-1:0] BLK_STATES_PER_BYTE = 16'h0004;
  localparam logic [STATES_W-1:0] BLK_STATES_BASE = 16'h0009;

  // Internal cycles of multiply and divide.
  localparam int MULDIV_INTERNAL = 12;

  // Reset values.
  localparam logic [STATES_W-1:0] STATES_RST = 16'h0000;

  typedef enum logic [3:0] {
    ISC_CLS_ILLEGAL,
    ISC_CLS_CTRL,
    ISC_CLS_REG_ALU,
    ISC_CLS_MOVE,
    ISC_CLS_BRANCH,
    ISC_CLS_CALL,
    ISC_CLS_JUMP,
    ISC_CLS_RETURN,
    ISC_CLS_MULDIV,
    ISC_CLS_BIT_REG,
    ISC_CLS_BIT_TEST_MEM,
    ISC_CLS_BIT_WRITE_MEM,
    ISC_CLS_BLOCK_MOVE
  } isc_class_e;

  // Cycle counts (or state costs) for the six cycle types.
  typedef struct packed {
    logic [CNT_W-1:0] fetch;
    logic [CNT_W-1:0] branch;
    logic [CNT_W-1:0] stack;
    logic [CNT_W-1:0] byte_acc;
    logic [CNT_W-1:0] word_acc;
    logic [CNT_W-1:0] internal;
  } isc_cycles_s;

  typedef struct packed {
    isc_class_e cls;
    isc_cycles_s counts;
  } isc_decode_s;

  // Registered result of one decoded instruction.
  typedef struct packed {
    logic valid;
    isc_class_e cls;
    logic variant;
    isc_cycles_s counts;
    logic [STATES_W-1:0] states;
  } isc_state_s;

endpackage : isc_pkg

// ---- core/isc_state_sum.sv ----
// Weighted sum of cycle counts into total execution states.
`timescale 1ns/1ps
module isc_state_sum (
  // Cycle counts and per-type costs
  input wire isc_pkg::isc_cycles_s i_counts,
  input wire isc_pkg::isc_cycles_s i_costs,
  // Block move override
  input wire logic i_block_move,
  input wire logic [isc_pkg::BLK_CNT_W-1:0] i_block_move_count_reg,
  // Total
  output logic [isc_pkg::STATES_W-1:0] o_states
);

  function automatic logic [isc_pkg::STATES_W-1:0] weigh(
    input logic [isc_pkg::CNT_W-1:0] cnt,
    input logic [isc_pkg::CNT_W-1:0] cost
  );
    logic [2*isc_pkg::CNT_W-1:0] prod;
    prod = cnt * cost;
    return {{(isc_pkg::STATES_W-2*isc_pkg::CNT_W){1'b0}}, prod};
  endfunction : weigh

  logic [isc_pkg::STATES_W-1:0] n_ext;

  always_comb begin
    n_ext = {{(isc_pkg::STATES_W-isc_pkg::BLK_CNT_W){1'b0}}, i_block_move_count_reg};
    if (i_block_move) begin
      // Repeat count is taken as it stands when the instruction is decoded.
      o_states = 16'(n_ext * isc_pkg::BLK_STATES_PER_BYTE) + isc_pkg::BLK_STATES_BASE;
    end else begin
      o_states = weigh(i_counts.fetch, i_costs.fetch)
               + weigh(i_counts.branch, i_costs.branch)
               + weigh(i_counts.stack, i_costs.stack)
               + weigh(i_counts.byte_acc, i_costs.byte_acc)
               + weigh(i_counts.word_acc, i_costs.word_acc)
               + weigh(i_counts.internal, i_costs.internal);
    end
  end

endmodule : isc_state_sum

// ---- core/isc_top.sv ----
// Instruction decoder that counts cycles and execution states per instruction.
`timescale 1ns/1ps
module isc_top (
  // Clock, reset and enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Instruction in
  input wire logic i_valid,
  input wire logic [15:0] i_instr_word,
  input wire logic [isc_pkg::BLK_CNT_W-1:0] i_block_move_count_reg,
  // Data access location
  input wire logic i_byte_periph,
  input wire logic i_periph_slow,
  // Result out
  output logic o_valid,
  output isc_pkg::isc_class_e o_class,
  output logic o_variant,
  output isc_pkg::isc_cycles_s o_counts,
  output logic [isc_pkg::STATES_W-1:0] o_states
);

  function automatic isc_pkg::isc_cycles_s cyc(
    input int i,
    input int j,
    input int k,
    input int l,
    input int m,
    input int n
  );
    isc_pkg::isc_cycles_s c;
    c.fetch = 4'(i);
    c.branch = 4'(j);
    c.stack = 4'(k);
    c.byte_acc = 4'(l);
    c.word_acc = 4'(m);
    c.internal = 4'(n);
    return c;
  endfunction : cyc

  function automatic isc_pkg::isc_decode_s decode(input logic [7:0] opc);
    isc_pkg::isc_decode_s d;
    d.cls = isc_pkg::ISC_CLS_ILLEGAL;
    d.counts = cyc(1, 0, 0, 0, 0, 0);
    casez (opc)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07: begin
        d.cls = isc_pkg::ISC_CLS_CTRL;
        d.counts = cyc(1, 0, 0, 0, 0, 0);
      end
      8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0f, 8'b0001_????: begin
        d.cls = isc_pkg::ISC_CLS_REG_ALU;
        d.counts = cyc(1, 0, 0, 0, 0, 0);
      end
      8'h0c, 8'h0d: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(1, 0, 0, 0, 0, 0);
      end
      8'b0010_????, 8'b0011_????: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(1, 0, 0, 1, 0, 0);
      end
      8'b0100_????: begin
        d.cls = isc_pkg::ISC_CLS_BRANCH;
        d.counts = cyc(2, 0, 0, 0, 0, 0);
      end
      8'h50, 8'h51: begin
        d.cls = isc_pkg::ISC_CLS_MULDIV;
        d.counts = cyc(1, 0, 0, 0, 0, isc_pkg::MULDIV_INTERNAL);
      end
      8'h54: begin
        d.cls = isc_pkg::ISC_CLS_RETURN;
        d.counts = cyc(2, 0, 1, 0, 0, 2);
      end
      8'h56: begin
        d.cls = isc_pkg::ISC_CLS_RETURN;
        d.counts = cyc(2, 0, 2, 0, 0, 2);
      end
      8'h55, 8'h5d: begin
        d.cls = isc_pkg::ISC_CLS_CALL;
        d.counts = cyc(2, 0, 1, 0, 0, 0);
      end
      8'h5e: begin
        d.cls = isc_pkg::ISC_CLS_CALL;
        d.counts = cyc(2, 0, 1, 0, 0, 2);
      end
      8'h5f: begin
        d.cls = isc_pkg::ISC_CLS_CALL;
        d.counts = cyc(2, 1, 1, 0, 0, 0);
      end
      8'h59: begin
        d.cls = isc_pkg::ISC_CLS_JUMP;
        d.counts = cyc(2, 0, 0, 0, 0, 0);
      end
      8'h5a: begin
        d.cls = isc_pkg::ISC_CLS_JUMP;
        d.counts = cyc(2, 0, 0, 0, 0, 2);
      end
      8'h5b: begin
        d.cls = isc_pkg::ISC_CLS_JUMP;
        d.counts = cyc(2, 1, 0, 0, 0, 2);
      end
      8'h60, 8'h61, 8'h62, 8'h63, 8'h67, 8'h70, 8'h71, 8'h72, 8'h73,
      8'h74, 8'h75, 8'h76, 8'h77: begin
        d.cls = isc_pkg::ISC_CLS_BIT_REG;
        d.counts = cyc(1, 0, 0, 0, 0, 0);
      end
      8'h68: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(1, 0, 0, 1, 0, 0);
      end
      8'h69: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(1, 0, 0, 0, 1, 0);
      end
      8'h6a, 8'h6e: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(2, 0, 0, 1, 0, 0);
      end
      8'h6b, 8'h6f: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(2, 0, 0, 0, 1, 0);
      end
      8'h6c: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(1, 0, 0, 1, 0, 2);
      end
      8'h6d: begin
        // Stack push and pop are this move with the stack pointer as base.
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(1, 0, 0, 0, 1, 2);
      end
      8'h79: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(2, 0, 0, 0, 0, 0);
      end
      8'h7b: begin
        d.cls = isc_pkg::ISC_CLS_BLOCK_MOVE;
        d.counts = cyc(2, 0, 0, 0, 0, 0);
      end
      8'h7c, 8'h7e: begin
        d.cls = isc_pkg::ISC_CLS_BIT_TEST_MEM;
        d.counts = cyc(2, 0, 0, 1, 0, 0);
      end
      8'h7d, 8'h7f: begin
        // Read-modify-write bit ops, bit_set_op among them.
        d.cls = isc_pkg::ISC_CLS_BIT_WRITE_MEM;
        d.counts = cyc(2, 0, 0, 2, 0, 0);
      end
      8'b1000_????, 8'b1001_????, 8'b1010_????, 8'b1011_????, 8'b1100_????,
      8'b1101_????, 8'b1110_????: begin
        d.cls = isc_pkg::ISC_CLS_REG_ALU;
        d.counts = cyc(1, 0, 0, 0, 0, 0);
      end
      8'b1111_????: begin
        d.cls = isc_pkg::ISC_CLS_MOVE;
        d.counts = cyc(1, 0, 0, 0, 0, 0);
      end
      default: begin
        d.cls = isc_pkg::ISC_CLS_ILLEGAL;
        d.counts = cyc(1, 0, 0, 0, 0, 0);
      end
    endcase
    return d;
  endfunction : decode

  isc_pkg::isc_state_s state_r;
  isc_pkg::isc_state_s state_nxt;
  isc_pkg::isc_decode_s dec;
  isc_pkg::isc_cycles_s costs;
  logic [isc_pkg::STATES_W-1:0] sum_states;

  always_comb begin
    dec = decode(i_instr_word[isc_pkg::OPC_HI:isc_pkg::OPC_LO]);
    costs.fetch = isc_pkg::COST_FETCH_MEM;
    costs.branch = isc_pkg::COST_BRANCH_MEM;
    costs.stack = isc_pkg::COST_STACK_MEM;
    costs.word_acc = isc_pkg::COST_WORD_MEM;
    costs.internal = isc_pkg::internal_state_cost;
    // Slow peripherals insert one extra state on each byte access.
    if (!i_byte_periph) begin
      costs.byte_acc = isc_pkg::COST_BYTE_MEM;
    end else if (i_periph_slow) begin
      costs.byte_acc = isc_pkg::COST_BYTE_PERI_SLOW;
    end else begin
      costs.byte_acc = isc_pkg::COST_BYTE_PERI_FAST;
    end
  end

  isc_state_sum u_sum (
    .i_counts(dec.counts),
    .i_costs(costs),
    .i_block_move(dec.cls == isc_pkg::ISC_CLS_BLOCK_MOVE),
    .i_block_move_count_reg(i_block_move_count_reg),
    .o_states(sum_states)
  );

  always_comb begin
    state_nxt = state_r;
    // A result stands one enabled cycle; idle cycles drop the strobe but keep the data.
    state_nxt.valid = i_valid;
    if (i_valid) begin
      state_nxt.cls = dec.cls;
      // Picks between the two instructions sharing an opcode.
      state_nxt.variant = i_instr_word[isc_pkg::VARIANT_BIT];
      state_nxt.counts = dec.counts;
      state_nxt.states = sum_states;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r <= '{valid: 1'b0, cls: isc_pkg::ISC_CLS_ILLEGAL, variant: 1'b0,
                   counts: '0, states: isc_pkg::STATES_RST};
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  assign o_valid = state_r.valid;
  assign o_class = state_r.cls;
  assign o_variant = state_r.variant;
  assign o_counts = state_r.counts;
  assign o_states = state_r.states;

endmodule : isc_top

// ---- bench/isc_checker.sv ----
// Port-level timing checks for the instruction state counter.
`timescale 1ns/1ps
module isc_checker (
  // Clock, reset and enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // Instruction in
  input wire logic i_valid,
  input wire logic [15:0] i_instr_word,
  input wire logic [isc_pkg::BLK_CNT_W-1:0] i_block_move_count_reg,
  input wire logic i_byte_periph,
  input wire logic i_periph_slow,
  // Result out
  input wire logic o_valid,
  input wire isc_pkg::isc_class_e o_class,
  input wire logic o_variant,
  input wire isc_pkg::isc_cycles_s o_counts,
  input wire logic [isc_pkg::STATES_W-1:0] o_states
);
  logic take;
  logic [7:0] opc;
  logic [3:0] lcost_r;
  logic [15:0] sum_exp;
  assign take = i_ce && i_valid;
  assign opc = i_instr_word[15:8];
  // Byte cost is registered so it lines up with the result one cycle later.
  always_ff @(posedge i_clock) begin
    lcost_r <= (i_byte_periph && i_periph_slow) ? 4'h3 : 4'h2;
  end
  assign sum_exp = 16'h0002 * ({12'h000, o_counts.fetch} + {12'h000, o_counts.branch}
    + {12'h000, o_counts.stack} + {12'h000, o_counts.word_acc})
    + {12'h000, o_counts.byte_acc} * {12'h000, lcost_r} + {12'h000, o_counts.internal};
  property p_lat;
    @(posedge i_clock) disable iff (i_rst) take |=> o_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("result strobe missing");
  property p_pulse;
    @(posedge i_clock) disable iff (i_rst) i_ce && !i_valid |=> !o_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe without request");
  property p_hold;
    @(posedge i_clock) disable iff (i_rst) !i_ce |=> $stable(o_states) && $stable(o_valid);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while frozen");
  property p_rst;
    @(posedge i_clock) i_rst |=> !o_valid && o_states == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_var;
    @(posedge i_clock) disable iff (i_rst) take ##1 1'b1 |-> o_variant == $past(i_instr_word[7]);
  endproperty
  a_var: assert property (p_var) else $error("variant bit wrong");
  property p_sum;
    @(posedge i_clock) disable iff (i_rst) take && opc != 8'h7b |=> o_states == sum_exp;
  endproperty
  a_sum: assert property (p_sum) else $error("weighted sum wrong");
  property p_blk;
    @(posedge i_clock) disable iff (i_rst) take && opc == 8'h7b ##1 1'b1
      |-> o_states == 16'h0004 * {8'h00, $past(i_block_move_count_reg)} + 16'h0009;
  endproperty
  a_blk: assert property (p_blk) else $error("block move states wrong");
  property p_bit_set_op;
    @(posedge i_clock) disable iff (i_rst) take && opc == 8'h7d |=> o_counts == 24'h200200;
  endproperty
  a_bit_set_op: assert property (p_bit_set_op) else $error("bit set counts wrong");
  property p_call;
    @(posedge i_clock) disable iff (i_rst) take && opc == 8'h5f |=> o_counts == 24'h211000;
  endproperty
  a_call: assert property (p_call) else $error("indirect call counts wrong");
  property p_alu;
    @(posedge i_clock) disable iff (i_rst) take && opc == 8'h08 |=> o_counts == 24'h100000;
  endproperty
  a_alu: assert property (p_alu) else $error("register alu counts wrong");
  property p_push;
    @(posedge i_clock) disable iff (i_rst) take && opc == 8'h6d
      |=> o_class == isc_pkg::ISC_CLS_MOVE;
  endproperty
  a_push: assert property (p_push) else $error("push not a move");
  c_blk: cover property (@(posedge i_clock) take && opc == 8'h7b);
  c_slow: cover property (@(posedge i_clock) take && i_byte_periph && i_periph_slow);
  c_b2b: cover property (@(posedge i_clock) take ##1 take);
endmodule : isc_checker
bind isc_top isc_checker i_chk (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
  .i_valid(i_valid), .i_instr_word(i_instr_word),
  .i_block_move_count_reg(i_block_move_count_reg), .i_byte_periph(i_byte_periph),
  .i_periph_slow(i_periph_slow), .o_valid(o_valid), .o_class(o_class),
  .o_variant(o_variant), .o_counts(o_counts), .o_states(o_states));

// ---- bench/isc_loc_model.sv ----
// Model of the data access location behind the core.
`timescale 1ns/1ps
module isc_loc_model (
  // Region select
  input wire logic [1:0] i_region,
  // Location seen by the core
  output logic o_byte_periph,
  output logic o_periph_slow
);
  // Region 0 is memory, 1 a fast peripheral, 2 and 3 slow peripherals.
  always_comb begin
    o_byte_periph = i_region != 2'h0;
    o_periph_slow = i_region[1];
  end
endmodule : isc_loc_model

// ---- bench/isc_top_tb.sv ----
// Self-checking testbench for the instruction state counter.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (a), (b)); end end
module isc_top_tb;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic ce = 1'b1;
  logic valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [7:0] cnt = 8'h00;
  logic [1:0] region = 2'h0;
  logic periph, slow, o_valid, o_variant;
  isc_pkg::isc_class_e o_class;
  isc_pkg::isc_cycles_s o_counts;
  logic [15:0] o_states;
  int n_fail = 0;
  int n_compared = 0;
  always #10 i_clock = ~i_clock;
  isc_loc_model i_loc (.i_region(region), .o_byte_periph(periph), .o_periph_slow(slow));
  isc_top i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(ce), .i_valid(valid),
    .i_instr_word(instr), .i_block_move_count_reg(cnt), .i_byte_periph(periph),
    .i_periph_slow(slow), .o_valid(o_valid), .o_class(o_class), .o_variant(o_variant),
    .o_counts(o_counts), .o_states(o_states));
  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // One request; the result is settled and its strobe up when this returns.
  task automatic issue(input logic [15:0] w, input logic [7:0] n, input logic [1:0] rg);
    @(posedge i_clock);
    #1 instr = w;
    cnt = n;
    region = rg;
    valid = 1'b1;
    @(posedge i_clock);
    #1 valid = 1'b0;
    `CHK(o_valid, 1'b1)
  endtask : issue
  task automatic t_bit_set_op();
    issue(16'h7d00, 8'h00, 2'h0);
    `CHK(o_counts, 24'h200200)
    `CHK(o_class, isc_pkg::ISC_CLS_BIT_WRITE_MEM)
    `CHK(o_states, 16'h0008)
    issue(16'h7d00, 8'h00, 2'h2);
    `CHK(o_states, 16'h000a)
    issue(16'h7d00, 8'h00, 2'h1);
    `CHK(o_states, 16'h0008)
  endtask : t_bit_set_op
  task automatic t_call();
    issue(16'h5f00, 8'h00, 2'h0);
    `CHK(o_counts, 24'h211000)
    `CHK(o_states, 16'h0008)
  endtask : t_call
  task automatic t_blk();
    logic [7:0] ns [2] = '{8'h00, 8'hff};
    foreach (ns[k]) begin
      issue(16'h7b5c, ns[k], 2'h2);
      `CHK(o_states, 16'h0004 * {8'h00, ns[k]} + 16'h0009)
    end
  endtask : t_blk
  task automatic t_ops();
    issue(16'h0812, 8'h00, 2'h0);
    `CHK(o_counts, 24'h100000)
    for (int b = 0; b < 16; b++) begin
      issue({4'h4, b[3:0], 8'h10}, 8'h00, 2'h0);
      `CHK(o_counts, 24'h200000)
    end
    issue(16'h5000, 8'h00, 2'h0);
    `CHK(o_states, 16'h000e)
    issue(16'h6df6, 8'h00, 2'h0);
    `CHK(o_class, isc_pkg::ISC_CLS_MOVE)
    `CHK(o_states, 16'h0006)
  endtask : t_ops
  task automatic t_field();
    issue(16'h087d, 8'h00, 2'h0);
    `CHK(o_states, 16'h0002)
    issue(16'h7dff, 8'h00, 2'h0);
    `CHK(o_variant, 1'b1)
    `CHK(o_states, 16'h0008)
    issue(16'h7d70, 8'h00, 2'h0);
    `CHK(o_variant, 1'b0)
  endtask : t_field
  task automatic t_ce();
    // Two requests back to back, each driven one small delay after its edge.
    @(posedge i_clock);
    #1 instr = 16'h0800;
    cnt = 8'h00;
    region = 2'h0;
    valid = 1'b1;
    @(posedge i_clock);
    #1 instr = 16'h5f00;
    `CHK(o_valid, 1'b1)
    `CHK(o_states, 16'h0002)
    @(posedge i_clock);
    #1 `CHK(o_states, 16'h0008)
    ce = 1'b0;
    instr = 16'h7b00;
    repeat (2) @(posedge i_clock);
    #1 `CHK(o_valid, 1'b1)
    `CHK(o_states, 16'h0008)
    ce = 1'b1;
    valid = 1'b0;
    @(posedge i_clock);
    #1 `CHK(o_valid, 1'b0)
  endtask : t_ce
  initial begin
    repeat (10) @(posedge i_clock);
    #1 i_rst = 1'b0;
    `CHK(o_valid, 1'b0)
    `CHK(o_states, 16'h0000)
    t_bit_set_op();
    t_call();
    t_blk();
    t_ops();
    t_field();
    t_ce();
    stop_test();
  end
  // The tests need well under a thousand cycles.
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule : isc_top_tb
